// ---- event_notify_stats_pkg.sv ----
// Summary of operation
// - Separate rise and fall events per input line
// - Acquisition begin sends message when enabled
// - Acquisition finish sends message when enabled
// - Queue overrun disables events, sends overrun message
// - Enable setting acts on selected event only
// - Disabled event type never queues new messages
// - Enabled choices: normal or legacy message format
// - Count frame triggers arriving while not permitted
// - Count images discarded before transfer completed
// - Count every retransmitted packet once
// - Bounded resend queue; dropped requests still counted
// - Pause frame count limited to 65535 events
// - Selector picks which statistic value reads
// - Clear command clears selected statistic only
`default_nettype none
package event_notify_stats_pkg;
    // ****************************************
    // Register bus and map
    // ****************************************
    localparam int          ADDR_W           = 5;
    localparam int          DATA_W           = 32;
    localparam logic [4:0]  OFS_EVT_CHOICE   = 5'h00;
    localparam logic [4:0]  OFS_EVT_ENABLE   = 5'h04;
    localparam logic [4:0]  OFS_STAT_CHOICE  = 5'h08;
    localparam logic [4:0]  OFS_STAT_VALUE   = 5'h0c;
    localparam logic [4:0]  OFS_STAT_CLEAR   = 5'h10;
    localparam logic [4:0]  OFS_IRQ_STATUS   = 5'h14;
    localparam logic [4:0]  OFS_IRQ_CLEAR    = 5'h18;
    localparam logic [4:0]  OFS_IRQ_ENABLE   = 5'h1c;
    // ****************************************
    // Event types and enable settings
    // ****************************************
    localparam int          NUM_LINES        = 3;
    localparam int          NUM_EVT          = 9;
    localparam int          EVT_W            = 4;
    localparam logic [3:0]  EVT_ACQ_BEGIN    = 4'h6;
    localparam logic [3:0]  EVT_ACQ_FINISH   = 4'h7;
    localparam logic [3:0]  EVT_OVERRUN      = 4'h8;
    localparam logic [1:0]  EN_OFF           = 2'h0;
    localparam logic [1:0]  EN_ON            = 2'h1;
    localparam logic [1:0]  EN_LEGACY        = 2'h2;
    localparam logic [1:0]  EN_BAD           = 2'h3;
    // ****************************************
    // Statistics
    // ****************************************
    localparam int          NUM_STAT         = 5;
    localparam int          STAT_W           = 3;
    localparam logic [2:0]  STAT_BAD_TRIG    = 3'h0;
    localparam logic [2:0]  STAT_DROP_IMG    = 3'h1;
    localparam logic [2:0]  STAT_RETX        = 3'h2;
    localparam logic [2:0]  STAT_RETX_DROP   = 3'h3;
    localparam logic [2:0]  STAT_PAUSE       = 3'h4;
    localparam logic [31:0] STAT_FULL_MAX    = 32'hffffffff;
    localparam logic [31:0] PAUSE_MAX        = 32'h0000ffff;
    localparam int          RESEND_DEPTH_DEF = 8;
    // ****************************************
    // Interrupt status bits
    // ****************************************
    localparam int          NUM_IRQ          = 3;
    localparam int          IRQ_OVERRUN      = 0;
    localparam int          IRQ_REQ_DROP     = 1;
    localparam int          IRQ_PAUSE_FULL   = 2;
endpackage
`default_nettype wire

// ---- event_notify_stats.sv ----
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module event_notify_stats #(
    parameter int RESEND_DEPTH = event_notify_stats_pkg::RESEND_DEPTH_DEF
) (
    input  wire logic                                     i_clk_sys,
    input  wire logic                                     i_reset,
    // Register port
    input  wire logic [event_notify_stats_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [event_notify_stats_pkg::DATA_W-1:0] i_wr_data,
    input  wire logic                                     i_wr_stb,
    input  wire logic                                     i_rd_stb,
    output logic      [event_notify_stats_pkg::DATA_W-1:0] o_rd_data,
    // Event sources
    input  wire logic [event_notify_stats_pkg::NUM_LINES-1:0] i_line,
    input  wire logic                                     i_acq_begin,
    input  wire logic                                     i_acq_finish,
    // Statistic sources
    input  wire logic                                     i_bad_frame_trig,
    input  wire logic                                     i_dropped_image,
    input  wire logic                                     i_retransmit,
    input  wire logic                                     i_resend_req,
    input  wire logic                                     i_resend_done,
    input  wire logic                                     i_pause_rx,
    output logic                                          o_resend_pending,
    // Control channel message port
    output logic                                          o_msg_valid,
    output logic      [event_notify_stats_pkg::EVT_W-1:0]  o_msg_code,
    output logic                                          o_msg_legacy,
    input  wire logic                                     i_msg_ready,
    // Interrupt
    output logic                                          o_irq
);
    import event_notify_stats_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic [EVT_W-1:0]          evt_choice;        // Selected event type
    logic [NUM_EVT-1:0][1:0]   evt_enable_setting; // Per event setting
    logic [STAT_W-1:0]         stat_choice;       // Selected statistic
    logic [NUM_STAT-1:0][31:0] stat_cnt;          // Statistic counters
    logic [NUM_STAT-1:0]       stat_inc;          // Increment strobes
    logic [NUM_LINES-1:0]      line_prev;         // Previous line levels
    logic                      line_seen;         // Previous levels valid
    logic [NUM_EVT-1:0]        evt_hit;           // Enabled events now
    logic [NUM_EVT-1:0]        pend;              // Messages waiting
    logic [NUM_EVT-1:0]        pend_legacy;       // Format per waiting msg
    logic [NUM_EVT-1:0]        next_pend;
    logic [NUM_EVT-1:0]        next_pend_legacy;
    logic [NUM_EVT-1:0]        serve_mask;        // Message taken this cycle
    logic                      overrun;           // Queue overflow now
    logic                      msg_load;          // Output stage loads
    logic [EVT_W-1:0]          pick;              // Next message to send
    logic [7:0]                resend_fill;       // Resend queue fill level
    logic                      resend_full;
    logic                      req_drop;          // Resend request dropped
    logic                      pause_full;        // Pause counter at limit
    logic [NUM_IRQ-1:0]        irq_status;
    logic [NUM_IRQ-1:0]        irq_enable;
    logic [NUM_IRQ-1:0]        irq_set;
    logic                      wr_enable;
    logic                      wr_stat_clear;
    logic                      wr_irq_clear;

    assign wr_enable     = i_wr_stb && (i_addr == OFS_EVT_ENABLE);
    assign wr_stat_clear = i_wr_stb && (i_addr == OFS_STAT_CLEAR);
    assign wr_irq_clear  = i_wr_stb && (i_addr == OFS_IRQ_CLEAR);

    // ****************************************
    // Edge detection on input lines
    // ****************************************
    // First cycle after reset only learns the levels, so a line that is
    // already high is not reported as a rising edge.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            line_prev <= '0;
            line_seen <= 1'b0;
        end else begin
            line_prev <= i_line;
            line_seen <= 1'b1;
        end
    end

    // Rise on even index, fall on odd index, gated by the setting
    genvar gl;
    generate
        for (gl = 0; gl < NUM_LINES; gl++) begin : g_line
            assign evt_hit[2*gl] = line_seen && i_line[gl] && !line_prev[gl]
                && (evt_enable_setting[2*gl] != EN_OFF);
            assign evt_hit[2*gl+1] = line_seen && !i_line[gl] && line_prev[gl]
                && (evt_enable_setting[2*gl+1] != EN_OFF);
        end
    endgenerate

    // Acquisition events; overrun is raised internally, never by a source
    assign evt_hit[EVT_ACQ_BEGIN]  = i_acq_begin
        && (evt_enable_setting[EVT_ACQ_BEGIN] != EN_OFF);
    assign evt_hit[EVT_ACQ_FINISH] = i_acq_finish
        && (evt_enable_setting[EVT_ACQ_FINISH] != EN_OFF);
    assign evt_hit[EVT_OVERRUN]    = 1'b0;

    // ****************************************
    // Event selector and enable settings
    // ****************************************
    // Selector writes naming no event type are ignored
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            evt_choice <= '0;
        end else if (i_wr_stb && (i_addr == OFS_EVT_CHOICE)
                     && (i_wr_data[EVT_W-1:0] < EVT_W'(NUM_EVT))) begin
            evt_choice <= i_wr_data[EVT_W-1:0];
        end
    end

    // Overrun wins over a host write in the same cycle: the device must
    // leave every ordinary event off until the host turns it on again.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            evt_enable_setting              <= '0;
            evt_enable_setting[EVT_OVERRUN] <= EN_ON;
        end else begin
            if (wr_enable && (i_wr_data[1:0] != EN_BAD)) begin
                evt_enable_setting[evt_choice] <= i_wr_data[1:0];
            end
            if (overrun) begin
                for (int i = 0; i < NUM_EVT; i++) begin
                    if (i != EVT_OVERRUN) begin
                        evt_enable_setting[i] <= EN_OFF;
                    end
                end
            end
        end
    end

    // ****************************************
    // Message queue, one slot per event type
    // ****************************************
    // Highest index first, so the overrun message leaves before others
    always_comb begin
        pick = '0;
        for (int i = 0; i < NUM_EVT; i++) begin
            if (pend[i]) begin
                pick = EVT_W'(i);
            end
        end
    end

    assign msg_load   = (!o_msg_valid || i_msg_ready) && (|pend);
    assign serve_mask = msg_load ? (NUM_EVT'(1) << pick) : '0;
    // A fresh event of a type still waiting means the queue cannot keep up
    assign overrun    = |(evt_hit & pend & ~serve_mask);

    // New event sets its slot even in the cycle the slot is served
    always_comb begin
        next_pend        = (pend & ~serve_mask) | evt_hit;
        next_pend_legacy = pend_legacy;
        for (int i = 0; i < NUM_EVT; i++) begin
            if (evt_hit[i]) begin
                next_pend_legacy[i] = (evt_enable_setting[i] == EN_LEGACY);
            end
        end
        if (overrun) begin
            // Queued ordinary messages are discarded; one overrun goes out
            next_pend = '0;
            next_pend[EVT_OVERRUN] =
                (evt_enable_setting[EVT_OVERRUN] != EN_OFF);
            next_pend_legacy[EVT_OVERRUN] =
                (evt_enable_setting[EVT_OVERRUN] == EN_LEGACY);
        end
    end

    // Queue state
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pend        <= '0;
            pend_legacy <= '0;
        end else begin
            pend        <= next_pend;
            pend_legacy <= next_pend_legacy;
        end
    end

    // Output stage holds a message until the channel takes it
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_msg_valid  <= 1'b0;
            o_msg_code   <= '0;
            o_msg_legacy <= 1'b0;
        end else if (msg_load) begin
            o_msg_valid  <= 1'b1;
            o_msg_code   <= pick;
            o_msg_legacy <= pend_legacy[pick];
        end else if (i_msg_ready) begin
            o_msg_valid  <= 1'b0;
        end
    end

    // ****************************************
    // Resend request queue fill level
    // ****************************************
    assign resend_full      = (resend_fill >= 8'(RESEND_DEPTH));
    assign req_drop         = i_resend_req && resend_full && !i_resend_done;
    assign o_resend_pending = (resend_fill != 8'h00);

    // Fill level only; the request contents live with the packet sender
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            resend_fill <= 8'h00;
        end else if (i_resend_req && !req_drop && !i_resend_done) begin
            resend_fill <= resend_fill + 8'h01;
        end else if (!i_resend_req && i_resend_done && o_resend_pending) begin
            resend_fill <= resend_fill - 8'h01;
        end
    end

    // ****************************************
    // Statistic counters
    // ****************************************
    assign stat_inc[STAT_BAD_TRIG]  = i_bad_frame_trig;
    assign stat_inc[STAT_DROP_IMG]  = i_dropped_image;
    assign stat_inc[STAT_RETX]      = i_retransmit;
    assign stat_inc[STAT_RETX_DROP] = req_drop;
    assign stat_inc[STAT_PAUSE]     = i_pause_rx;
    assign pause_full = (stat_cnt[STAT_PAUSE] == PAUSE_MAX);

    // Each counter runs on its own, whatever the selector shows; a clear
    // that meets an increment leaves a count of one so no event is lost.
    genvar gs;
    generate
        for (gs = 0; gs < NUM_STAT; gs++) begin : g_stat
            localparam logic [31:0] LIMIT =
                (gs == STAT_PAUSE) ? PAUSE_MAX : STAT_FULL_MAX;
            always_ff @(posedge i_clk_sys) begin
                if (i_reset) begin
                    stat_cnt[gs] <= '0;
                end else if (wr_stat_clear && (stat_choice == STAT_W'(gs))) begin
                    stat_cnt[gs] <= {31'h0, stat_inc[gs]};
                end else if (stat_inc[gs] && (stat_cnt[gs] != LIMIT)) begin
                    stat_cnt[gs] <= stat_cnt[gs] + 32'h1;
                end
            end
        end
    endgenerate

    // Statistic selector; out of range values are ignored
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            stat_choice <= '0;
        end else if (i_wr_stb && (i_addr == OFS_STAT_CHOICE)
                     && (i_wr_data[STAT_W-1:0] < STAT_W'(NUM_STAT))) begin
            stat_choice <= i_wr_data[STAT_W-1:0];
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    assign irq_set[IRQ_OVERRUN]    = overrun;
    assign irq_set[IRQ_REQ_DROP]   = req_drop;
    assign irq_set[IRQ_PAUSE_FULL] = i_pause_rx && pause_full;

    // Sticky status; a set in the clearing cycle survives
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            irq_status <= '0;
        end else if (wr_irq_clear) begin
            irq_status <= (irq_status & ~i_wr_data[NUM_IRQ-1:0]) | irq_set;
        end else begin
            irq_status <= irq_status | irq_set;
        end
    end

    // Interrupt enable mask
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            irq_enable <= '0;
        end else if (i_wr_stb && (i_addr == OFS_IRQ_ENABLE)) begin
            irq_enable <= i_wr_data[NUM_IRQ-1:0];
        end
    end

    assign o_irq = |(irq_status & irq_enable);

    // ****************************************
    // Read data, one cycle after the strobe
    // ****************************************
    // Write-only and unmapped offsets read as zero; data stand one cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_rd_data <= '0;
        end else if (i_rd_stb) begin
            unique case (i_addr)
                OFS_EVT_CHOICE:  o_rd_data <= {28'h0, evt_choice};
                OFS_EVT_ENABLE:  o_rd_data <= {30'h0, evt_enable_setting[evt_choice]};
                OFS_STAT_CHOICE: o_rd_data <= {29'h0, stat_choice};
                OFS_STAT_VALUE:  o_rd_data <= stat_cnt[stat_choice];
                OFS_IRQ_STATUS:  o_rd_data <= {29'h0, irq_status};
                OFS_IRQ_ENABLE:  o_rd_data <= {29'h0, irq_enable};
                default:         o_rd_data <= '0;
            endcase
        end else begin
            o_rd_data <= '0;
        end
    end

endmodule
`default_nettype wire

// ---- event_notify_stats_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module event_notify_stats_monitor
    import event_notify_stats_pkg::*;
#(
    parameter int RESEND_DEPTH = 8
) (
    input wire logic                                       i_clk_sys,
    input wire logic                                       i_reset,
    input wire logic [event_notify_stats_pkg::ADDR_W-1:0]  i_addr,
    input wire logic [event_notify_stats_pkg::DATA_W-1:0]  i_wr_data,
    input wire logic                                       i_wr_stb,
    input wire logic                                       i_rd_stb,
    input wire logic [event_notify_stats_pkg::DATA_W-1:0]  o_rd_data,
    input wire logic [event_notify_stats_pkg::NUM_LINES-1:0] i_line,
    input wire logic                                       i_acq_begin,
    input wire logic                                       i_acq_finish,
    input wire logic                                       i_bad_frame_trig,
    input wire logic                                       i_dropped_image,
    input wire logic                                       i_retransmit,
    input wire logic                                       i_resend_req,
    input wire logic                                       i_resend_done,
    input wire logic                                       i_pause_rx,
    input wire logic                                       o_resend_pending,
    input wire logic                                       o_msg_valid,
    input wire logic [event_notify_stats_pkg::EVT_W-1:0]   o_msg_code,
    input wire logic                                       o_msg_legacy,
    input wire logic                                       i_msg_ready,
    input wire logic                                       o_irq
);
    // ****************************************
    // Helpers
    // ****************************************
    wire logic stat_in;  // Any statistic source active
    assign stat_in = i_bad_frame_trig | i_dropped_image | i_retransmit | i_resend_req | i_pause_rx;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    // ****************************************
    // Checks
    // ****************************************
    // Read data only in the cycle after a read strobe
    chk_rd_idle: assert property (!$past(i_rd_stb) |-> o_rd_data == '0)
        else $error("read data not idle");
    // A stalled message must not change under the host
    chk_msg_hold: assert property (o_msg_valid && !i_msg_ready |=>
        o_msg_valid && $stable(o_msg_code) && $stable(o_msg_legacy))
        else $error("message changed while stalled");
    chk_code_range: assert property (o_msg_valid |-> o_msg_code <= EVT_OVERRUN)
        else $error("message code out of range");
    chk_pend_rise: assert property ($rose(o_resend_pending) |-> $past(i_resend_req))
        else $error("pending rose without request");
    chk_pend_fall: assert property ($fell(o_resend_pending) |->
        $past(i_resend_done) && !$past(i_resend_req))
        else $error("pending fell without service");
    chk_req_fill: assert property (i_resend_req && !i_resend_done |=> o_resend_pending)
        else $error("request left queue empty");
    // Interrupt may only rise after a host write or a source event
    chk_irq_cause: assert property ($rose(o_irq) |->
        $past(i_wr_stb | i_resend_req | i_pause_rx | i_acq_begin | i_acq_finish)
        || $past(i_line) != $past(i_line, 2))
        else $error("interrupt rose without cause");
    chk_stat_clear: assert property ((i_wr_stb && i_addr == OFS_STAT_CLEAR && !stat_in)
        ##1 (i_rd_stb && i_addr == OFS_STAT_VALUE && !stat_in) |=> o_rd_data == '0)
        else $error("cleared statistic not zero");
endmodule
bind event_notify_stats event_notify_stats_monitor #(.RESEND_DEPTH(RESEND_DEPTH)) u_mon (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_line(i_line),
    .i_acq_begin(i_acq_begin), .i_acq_finish(i_acq_finish),
    .i_bad_frame_trig(i_bad_frame_trig), .i_dropped_image(i_dropped_image),
    .i_retransmit(i_retransmit), .i_resend_req(i_resend_req), .i_resend_done(i_resend_done),
    .i_pause_rx(i_pause_rx), .o_resend_pending(o_resend_pending), .o_msg_valid(o_msg_valid),
    .o_msg_code(o_msg_code), .o_msg_legacy(o_msg_legacy), .i_msg_ready(i_msg_ready),
    .o_irq(o_irq));
`default_nettype wire

// ---- host_channel_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_channel_model (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_stall,
    output logic     o_msg_ready
);
    // ****************************************
    // Host consumer pacing
    // ****************************************
    logic [1:0] pace;  // Skips one cycle in four so holds are seen
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pace        <= 2'h0;
            o_msg_ready <= 1'b0;
        end else begin
            pace        <= pace + 2'h1;
            o_msg_ready <= !i_stall && pace != 2'h3;
        end
    end
endmodule
`default_nettype wire

// ---- event_notify_stats_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module event_notify_stats_bench;
    import event_notify_stats_pkg::*;
    localparam int DEPTH = 2;  // Small queue keeps drops cheap to reach
    logic        i_clk_sys, i_reset, i_wr_stb, i_rd_stb, i_acq_begin, i_acq_finish;
    logic        i_resend_done, stall, o_resend_pending, o_msg_valid, o_msg_legacy;
    logic        i_msg_ready, o_irq;
    logic [4:0]  i_addr, pulse;
    logic [31:0] i_wr_data, o_rd_data, seed;
    logic [2:0]  i_line;
    logic [3:0]  o_msg_code;
    int          n_fail, compares, lax, saw8, n, stat[5], en[9];
    logic [4:0]  expq[$];  // Expected {legacy, code} in order
    event_notify_stats #(.RESEND_DEPTH(DEPTH)) u_dut (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .i_line(i_line),
        .i_acq_begin(i_acq_begin), .i_acq_finish(i_acq_finish), .i_bad_frame_trig(pulse[0]),
        .i_dropped_image(pulse[1]), .i_retransmit(pulse[2]), .i_resend_req(pulse[3]),
        .i_resend_done(i_resend_done), .i_pause_rx(pulse[4]),
        .o_resend_pending(o_resend_pending), .o_msg_valid(o_msg_valid),
        .o_msg_code(o_msg_code), .o_msg_legacy(o_msg_legacy), .i_msg_ready(i_msg_ready),
        .o_irq(o_irq));
    host_channel_model u_host (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_stall(stall),
        .o_msg_ready(i_msg_ready));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk_rd(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_msg(logic [4:0] got, logic [4:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: msg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_stb <= 1'b1;
        @(posedge i_clk_sys);
        i_wr_stb <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [4:0] a, logic [31:0] e);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wr_stb <= 1'b0;
        i_rd_stb <= 1'b1;
        @(posedge i_clk_sys);
        i_rd_stb <= 1'b0;
        #1 chk_rd(o_rd_data, e);
    endtask
    // Host picks the event before touching its setting
    task automatic set_en(int c, int v);
        wr(OFS_EVT_CHOICE, c);
        wr(OFS_EVT_ENABLE, v);
        if (v < 3) en[c] = v;
    endtask
    task automatic fire(int c);
        if (en[c] != 0) expq.push_back({en[c] == 2, 4'(c)});
        @(posedge i_clk_sys);
        if (c < 6) i_line <= i_line ^ (3'h1 << (c / 2));
        else if (c == 6) i_acq_begin <= 1'b1;
        else i_acq_finish <= 1'b1;
        @(posedge i_clk_sys);
        {i_acq_begin, i_acq_finish} <= 2'b00;
    endtask
    // Bounded wait for the host to take every expected message
    task automatic drain();
        for (int k = 0; k < 40 && expq.size() > 0; k++) @(posedge i_clk_sys);
        chk_rd(expq.size(), 0);
    endtask
    task automatic final_report();
        if (n_fail == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // Clock, message checker, watchdog
    // ****************************************
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        if (o_msg_valid && i_msg_ready) begin
            if (lax != 0) saw8 += (o_msg_code == EVT_OVERRUN);
            else if (expq.size() == 0) chk_msg({o_msg_legacy, o_msg_code}, 5'h1f);
            else chk_msg({o_msg_legacy, o_msg_code}, expq.pop_front());
        end
    end
    initial begin
        #2500000;
        n_fail++;
        final_report();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {i_reset, i_wr_stb, i_rd_stb, i_acq_begin, i_acq_finish} = 5'h10;
        {i_resend_done, stall, i_addr, pulse, i_line, i_wr_data} = '0;
        {n_fail, compares, lax, saw8, seed} = {128'h0, 32'hcf9e};
        foreach (en[c]) en[c] = (c == 8);
        foreach (stat[s]) stat[s] = 0;
        repeat (6) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        for (int c = 0; c < 9; c++) begin
            wr(OFS_EVT_CHOICE, c);
            rd(OFS_EVT_ENABLE, en[c]);
        end
        rd(5'h02, 32'h0);
        for (int c = 0; c < 8; c++) set_en(c, 1 + c % 2);
        wr(OFS_EVT_ENABLE, 3);
        wr(OFS_EVT_CHOICE, 9);
        rd(OFS_EVT_CHOICE, 7);
        rd(OFS_EVT_ENABLE, 2);
        for (int c = 0; c < 8; c++) begin
            fire(c);
            drain();
        end
        set_en(6, 0);
        fire(6);
        repeat (10) @(posedge i_clk_sys);
        // Stalled host, repeated finish events overrun the queue
        wr(OFS_IRQ_ENABLE, 1);
        lax = 1;
        stall <= 1'b1;
        i_acq_finish <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        i_acq_finish <= 1'b0;
        stall <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
        lax = 0;
        chk_rd(saw8, 1);
        rd(OFS_IRQ_STATUS, 32'h1);
        for (int c = 0; c < 8; c++) begin
            en[c] = 0;
            wr(OFS_EVT_CHOICE, c);
            rd(OFS_EVT_ENABLE, 0);
        end
        wr(OFS_IRQ_ENABLE, 0);
        #1 chk_rd(o_irq, 0);
        wr(OFS_IRQ_ENABLE, 1);
        #1 chk_rd(o_irq, 1);
        rd(OFS_IRQ_ENABLE, 32'h1);
        wr(OFS_IRQ_CLEAR, 1);
        #1 chk_rd(o_irq, 0);
        set_en(6, 1);
        fire(6);
        drain();
        // Random bursts on every statistic source except pause
        for (int s = 0; s < 4; s++) begin
            seed = lfsr(seed);
            n = seed % 8 + 1;
            stat[s] += n;
            @(posedge i_clk_sys);
            pulse[s] <= 1'b1;
            repeat (n + (s == 3 ? DEPTH : 0)) @(posedge i_clk_sys);
            pulse[s] <= 1'b0;
        end
        #1 chk_rd(o_resend_pending, 1);
        @(posedge i_clk_sys);
        pulse[4] <= 1'b1;
        repeat (65540) @(posedge i_clk_sys);
        pulse[4] <= 1'b0;
        stat[4] = 65535;
        i_resend_done <= 1'b1;
        repeat (DEPTH) @(posedge i_clk_sys);
        i_resend_done <= 1'b0;
        #1 chk_rd(o_resend_pending, 0);
        rd(OFS_IRQ_STATUS, 32'h6);
        for (int s = 0; s < 5; s++) begin
            wr(OFS_STAT_CHOICE, s);
            rd(OFS_STAT_VALUE, stat[s]);
        end
        wr(OFS_STAT_CHOICE, 5);
        rd(OFS_STAT_CHOICE, 4);
        // Clear then read back to back on the selected statistic
        wr(OFS_STAT_CHOICE, 2);
        @(posedge i_clk_sys);
        i_addr <= OFS_STAT_CLEAR;
        i_wr_stb <= 1'b1;
        stat[2] = 0;
        rd(OFS_STAT_VALUE, 0);
        for (int s = 0; s < 5; s++) begin
            wr(OFS_STAT_CHOICE, s);
            rd(OFS_STAT_VALUE, stat[s]);
        end
        final_report();
    end
endmodule
`default_nettype wire
